// ==== hw/tlm_match.sv ====
// Purpose: associative compare of one key against every translation entry
// Assumes: entries marked invalid never match
// Notes:   pure combinational; lowest matching index wins
module tlm_match import tlm_pkg::*; #(
   parameter int ENTRIES = 16,
   parameter int IDX_W   = $clog2(ENTRIES)
) (
   input  tlm_entry_t               ents [ENTRIES], // whole array
   input  wire logic [VPN_W-1:0]    key_virtual_page_pair_number,       // page pair to find
   input  wire logic [ADDRESS_SPACE_TAG_W-1:0]   key_address_space_tag,       // address space tag
   input  wire logic                excl_en,        // skip one entry
   input  wire logic [IDX_W-1:0]    excl_idx,       // entry to skip
   output logic                     hit,            // any match
   output logic                     multi,          // two or more
   output logic [IDX_W-1:0]         idx             // first match
);

   logic [ENTRIES-1:0] hv;

   for (genvar i = 0; i < ENTRIES; i++) begin : g_cmp
      logic [VPN_W-1:0] care;
      assign care  = ~{{(VPN_W-PMASK_W){1'b0}}, ents[i].mask};
      assign hv[i] = !ents[i].inv                                        // [RULE19]
                     && (((ents[i].virtual_page_pair_number ^ key_virtual_page_pair_number) & care) == '0)
                     && (ents[i].g || ents[i].address_space_tag == key_address_space_tag)
                     && !(excl_en && excl_idx == IDX_W'(i));
   end

   always_comb begin
      idx = '0;
      for (int i = ENTRIES - 1; i >= 0; i--) begin
         if (hv[i]) begin
            idx = IDX_W'(i);
         end
      end
   end

   assign hit   = |hv;
   assign multi = |(hv & (hv - ENTRIES'(1)));

endmodule

// ==== hw/tlm_pkg.sv ====
// Purpose: shared constants and types for the translation maintenance block
// Assumes: 32-bit system coprocessor register layout
// Notes:   offsets, field positions and reset values live here, except attribute bit slices and STATE_RST kept in the top module
package tlm_pkg;

   // ----------------------------------------------------------------
   // instruction decode
   // ----------------------------------------------------------------
   localparam logic [5:0] OPC_SYSCOP = 6'h10;   // 010000
   localparam int         CO_BIT     = 25;
   localparam logic [5:0] FN_PROBE   = 6'h08;   // 001000
   localparam logic [5:0] FN_READ    = 6'h01;   // 000001
   localparam logic [5:0] FN_WR_IDX  = 6'h02;   // 000010
   localparam logic [5:0] FN_WR_REP  = 6'h06;   // 000110

   typedef enum logic [4:0] {
      OP_NONE  = 5'h01,
      OP_PROBE = 5'h02,
      OP_READ  = 5'h04,
      OP_WRI   = 5'h08,
      OP_WRR   = 5'h10
   } tlm_op_t;

   // ----------------------------------------------------------------
   // register field layout
   // ----------------------------------------------------------------
   localparam int KEY_VPN_LSB   = 13;
   localparam int KEY_ENTRY_INVALIDATE_FLAG_BIT = 10;
   localparam int LO_PFN_LSB    = 6;
   localparam int MASK_LSB      = 13;
   localparam int PTR_MISS_BIT  = 31;
   localparam int VPN_W         = 19;
   localparam int ADDRESS_SPACE_TAG_W        = 8;
   localparam int PFN_W         = 20;
   localparam int PMASK_W       = 16;

   localparam logic [31:0] KEY_WMASK  = 32'hFFFFE4FF;
   localparam logic [31:0] LO_WMASK   = 32'h03FFFFFF;
   localparam logic [31:0] PM_WMASK   = 32'h1FFFE000;
   localparam logic [31:0] REG_RST    = 32'h00000000;
   localparam logic [31:0] ENTRY_INVALIDATE_FLAG_ONLY = 32'h00000400;

   // software register select codes
   localparam logic [2:0] SEL_KEY  = 3'h0;
   localparam logic [2:0] SEL_LO0  = 3'h1;
   localparam logic [2:0] SEL_LO1  = 3'h2;
   localparam logic [2:0] SEL_MASK = 3'h3;
   localparam logic [2:0] SEL_PTR  = 3'h4;

   localparam logic [2:0] ISL_INV_MIN = 3'h2;
   localparam logic [1:0] REV_THREE   = 2'h3;

   // ----------------------------------------------------------------
   // translation entry
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                inv;
      logic [VPN_W-1:0]    virtual_page_pair_number;
      logic [PMASK_W-1:0]  mask;
      logic [ADDRESS_SPACE_TAG_W-1:0]   address_space_tag;
      logic                g;
      logic [PFN_W-1:0]    pfn0;
      logic [2:0]          c0;
      logic                d0;
      logic                v0;
      logic [PFN_W-1:0]    pfn1;
      logic [2:0]          c1;
      logic                d1;
      logic                v1;
   } tlm_entry_t;

   localparam tlm_entry_t ENTRY_RST = '{inv: 1'b1, default: '0};

endpackage

// ==== hw/tlm_top.sv ====
// Purpose: translation buffer maintenance: probe, read, indexed and replacement write
// Assumes: pipeline presents one instruction word per cycle, same clock
// Notes:   every op completes in one cycle; results appear after the next edge
//
// Operation
// RULE1: decode major opcode 010000, op bit set, bits 24..6 zero, by function
// RULE2: probe loads the pointer with the index of the entry matching the key
// RULE3: probe miss sets the pointer's top bit
// RULE4: third revision may flag multiple matches on probe or write
// RULE5: second revision flags multiple matches only on writes
// RULE6: first revision flags multiple matches only on writes, as recommended
// RULE7: third revision may flag multiple matches on read
// RULE8: read fills key, both attributes and mask from the pointed entry
// RULE9: invalidation support and invalid entry: read returns zeros plus invalidate flag
// RULE10: read zeroes page and frame bits under mask ones, when configured
// RULE11: read returns the single global bit in both attribute registers
// RULE12: software keeps the pointer below the entry count before read or write
// RULE13: coprocessor disabled raises unusable fault instead of the operation
// RULE14: normal indexed write loads the entry from key, attributes and mask
// RULE15: multiple match found during write raises a machine check
// RULE16: write zeroes page and frame bits under mask ones, when configured
// RULE17: write stores global bit as AND of both attribute global bits
// RULE18: invalidating indexed write only marks the entry invalid, no machine check
// RULE19: entries marked invalid are skipped in translation matching
// RULE20: replacement write loads entry at replacement pointer, same rules as indexed; here the invalidate flag is ignored and a normal entry is written
// RULE21: normal write clears the entry's invalid marker
module tlm_top import tlm_pkg::*; #(
   parameter int   ENTRIES      = 16,
   parameter int   IDX_W        = $clog2(ENTRIES),
   parameter logic ZERO_MASKED  = 1'b1,
   parameter logic WR_MULTI_CHK = 1'b1
) (
   input  wire logic               clk_sys,                  // 125 MHz
   input  wire logic               rst_n,                    // sync, low
   input  wire logic               instr_valid,              // word present
   input  wire logic [31:0]        instr_word,               // instruction
   input  wire logic               cp0_usable,               // access enabled
   input  wire logic [1:0]         arch_rev,                 // 1..3
   input  wire logic [2:0]         invalidate_support_level, // 0..3
   input  wire logic [IDX_W-1:0]   replacement_ptr,          // replace slot
   input  wire logic               sw_wr_en,                 // register write
   input  wire logic [2:0]         sw_wr_sel,                // which register
   input  wire logic [31:0]        sw_wr_data,               // write data
   input  wire logic               lookup_valid,             // translate req
   input  wire logic [VPN_W-1:0]   lookup_virtual_page_pair_number,              // page pair
   input  wire logic [ADDRESS_SPACE_TAG_W-1:0]  lookup_address_space_tag,              // address space
   output logic [31:0]             tlb_key_hi_reg,           // key register
   output logic [31:0]             even_page_attr_reg,       // even attrs
   output logic [31:0]             odd_page_attr_reg,        // odd attrs
   output logic [31:0]             page_size_mask_reg,       // mask register
   output logic [31:0]             entry_pointer_reg,        // index register
   output logic                    op_done,                  // op finished
   output logic                    cop_unusable,             // fault pulse
   output logic                    machine_check,            // fault pulse
   output logic                    lookup_hit,               // translate hit
   output logic [IDX_W-1:0]        lookup_index              // hit entry
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0]      key;
      logic [31:0]      lo0;
      logic [31:0]      lo1;
      logic [31:0]      pmask;
      logic [31:0]      ptr;
      logic             done;
      logic             cpu;
      logic             mchk;
      logic             lk_hit;
      logic [IDX_W-1:0] lk_idx;
   } tlm_state_t;

   localparam tlm_state_t STATE_RST = '{default: '0};

   tlm_state_t st_r;
   tlm_state_t st_nxt;
   tlm_entry_t tlb_q [ENTRIES];

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic tlm_op_t op_decode(input logic [31:0] w);
      op_decode = OP_NONE;
      if (w[31:26] == OPC_SYSCOP && w[CO_BIT] && w[24:6] == '0) begin  // [RULE1]
         case (w[5:0])
            FN_PROBE:  op_decode = OP_PROBE;
            FN_READ:   op_decode = OP_READ;
            FN_WR_IDX: op_decode = OP_WRI;
            FN_WR_REP: op_decode = OP_WRR;
            default:   op_decode = OP_NONE;
         endcase
      end
   endfunction

   // masked low bits are implementation choice; zeroing keeps compares clean
   function automatic logic [PFN_W-1:0] mask_off(input logic [PFN_W-1:0] v,
                                                 input logic [PMASK_W-1:0] m);
      mask_off = ZERO_MASKED ? (v & ~{{(PFN_W-PMASK_W){1'b0}}, m}) : v;
   endfunction

   // ----------------------------------------------------------------
   // decode and match
   // ----------------------------------------------------------------
   tlm_op_t             op;
   logic                is_op;
   logic                go;
   logic                isl_inv;
   logic                inval_wr;
   logic [IDX_W-1:0]    sel_idx;
   tlm_entry_t          rd_e;
   logic [VPN_W-1:0]    m_virtual_page_pair_number;
   logic [ADDRESS_SPACE_TAG_W-1:0]   m_address_space_tag;
   logic                m_excl;
   logic [IDX_W-1:0]    m_excl_idx;
   logic                m_hit;
   logic                m_multi;
   logic [IDX_W-1:0]    m_idx;
   logic                l_hit;
   logic [IDX_W-1:0]    l_idx;
   logic                mc;
   logic                tlb_we;
   logic [IDX_W-1:0]    tlb_wa;
   tlm_entry_t          tlb_wd;
   tlm_entry_t          new_e;

   assign op       = instr_valid ? op_decode(instr_word) : OP_NONE;
   assign is_op    = op != OP_NONE;
   assign go       = is_op && cp0_usable;                             // [RULE13]
   assign isl_inv  = invalidate_support_level >= ISL_INV_MIN;
   assign inval_wr = isl_inv && st_r.key[KEY_ENTRY_INVALIDATE_FLAG_BIT];
   // only the low index bits select; larger pointers are the caller's fault
   assign sel_idx  = st_r.ptr[IDX_W-1:0];                             // [RULE12]
   assign rd_e     = tlb_q[sel_idx];

   // read compares the stored entry, the others compare the key register
   always_comb begin
      m_virtual_page_pair_number     = st_r.key[31:KEY_VPN_LSB];
      m_address_space_tag     = st_r.key[ADDRESS_SPACE_TAG_W-1:0];
      m_excl     = 1'b1;
      m_excl_idx = sel_idx;
      unique case (op)
         OP_PROBE: m_excl = 1'b0;
         OP_READ: begin
            m_virtual_page_pair_number = rd_e.virtual_page_pair_number;
            m_address_space_tag = rd_e.address_space_tag;
         end
         OP_WRR:   m_excl_idx = replacement_ptr;
         OP_WRI, OP_NONE: begin
         end
      endcase
   end

   tlm_match #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_op_match (
      .ents     (tlb_q),
      .key_virtual_page_pair_number (m_virtual_page_pair_number),
      .key_address_space_tag (m_address_space_tag),
      .excl_en  (m_excl),
      .excl_idx (m_excl_idx),
      .hit      (m_hit),
      .multi    (m_multi),
      .idx      (m_idx)
   );

   tlm_match #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_lookup (
      .ents     (tlb_q),
      .key_virtual_page_pair_number (lookup_virtual_page_pair_number),
      .key_address_space_tag (lookup_address_space_tag),
      .excl_en  (1'b0),
      .excl_idx ('0),
      .hit      (l_hit),
      .multi    (),
      .idx      (l_idx)
   );

   // ----------------------------------------------------------------
   // machine check
   // ----------------------------------------------------------------
   // on read and writes the target slot is excluded, so any other hit is a duplicate; probe excludes nothing and uses multi
   always_comb begin
      mc = 1'b0;
      if (go) begin
         unique case (op)
            OP_PROBE: mc = (arch_rev == REV_THREE) && m_multi;       // [RULE4] [RULE5] [RULE6]
            OP_READ:  mc = (arch_rev == REV_THREE) && !rd_e.inv      // [RULE7] [RULE5] [RULE6]
                           && m_hit;
            OP_WRI:   mc = WR_MULTI_CHK && !inval_wr && m_hit;       // [RULE15] [RULE18]
            OP_WRR:   mc = WR_MULTI_CHK && m_hit;                    // [RULE15] [RULE20]
            OP_NONE:  mc = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // entry image from the registers
   // ----------------------------------------------------------------
   always_comb begin
      logic [PMASK_W-1:0] pm;
      pm         = st_r.pmask[MASK_LSB +: PMASK_W];
      new_e      = ENTRY_RST;
      new_e.inv  = 1'b0;                                              // [RULE21]
      new_e.mask = pm;                                                // [RULE14]
      new_e.virtual_page_pair_number = VPN_W'(mask_off(PFN_W'(st_r.key[31:KEY_VPN_LSB]), pm)); // [RULE16]
      new_e.address_space_tag = st_r.key[ADDRESS_SPACE_TAG_W-1:0];
      new_e.g    = st_r.lo0[0] & st_r.lo1[0];                         // [RULE17]
      new_e.pfn0 = mask_off(st_r.lo0[LO_PFN_LSB +: PFN_W], pm);       // [RULE16]
      new_e.c0   = st_r.lo0[5:3];
      new_e.d0   = st_r.lo0[2];
      new_e.v0   = st_r.lo0[1];
      new_e.pfn1 = mask_off(st_r.lo1[LO_PFN_LSB +: PFN_W], pm);
      new_e.c1   = st_r.lo1[5:3];
      new_e.d1   = st_r.lo1[2];
      new_e.v1   = st_r.lo1[1];
   end

   // a write that raises a machine check leaves the array untouched
   always_comb begin
      tlb_we = 1'b0;
      tlb_wa = sel_idx;
      tlb_wd = new_e;
      if (go && !mc && op == OP_WRI) begin
         tlb_we = 1'b1;                                               // [RULE14]
         if (inval_wr) begin
            tlb_wd     = rd_e;                                        // [RULE18]
            tlb_wd.inv = 1'b1;
         end
      end else if (go && !mc && op == OP_WRR) begin
         tlb_we = 1'b1;                                               // [RULE20]
         tlb_wa = replacement_ptr;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < ENTRIES; i++) begin
            tlb_q[i] <= ENTRY_RST;
         end
      end else if (tlb_we) begin
         tlb_q[tlb_wa] <= tlb_wd;
      end
   end

   // ----------------------------------------------------------------
   // register update
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt        = st_r;
      st_nxt.done   = go;
      st_nxt.cpu    = is_op && !cp0_usable;                           // [RULE13]
      st_nxt.mchk   = mc;
      st_nxt.lk_hit = lookup_valid && l_hit;                          // [RULE19]
      st_nxt.lk_idx = lookup_valid ? l_idx : st_r.lk_idx;
      // an op in the same cycle wins over a software register write
      if (sw_wr_en && !go) begin
         unique case (sw_wr_sel)
            SEL_KEY:  st_nxt.key   = sw_wr_data & KEY_WMASK;
            SEL_LO0:  st_nxt.lo0   = sw_wr_data & LO_WMASK;
            SEL_LO1:  st_nxt.lo1   = sw_wr_data & LO_WMASK;
            SEL_MASK: st_nxt.pmask = sw_wr_data & PM_WMASK;
            SEL_PTR:  st_nxt.ptr   = 32'(sw_wr_data[IDX_W-1:0]);
            default: begin
            end
         endcase
      end
      if (go && !mc && op == OP_PROBE) begin
         if (m_hit) begin
            st_nxt.ptr = 32'(m_idx);                                  // [RULE2]
         end else begin
            st_nxt.ptr = REG_RST;
            st_nxt.ptr[PTR_MISS_BIT] = 1'b1;                          // [RULE3]
         end
      end
      if (go && !mc && op == OP_READ) begin
         if (isl_inv && rd_e.inv) begin
            st_nxt.key   = ENTRY_INVALIDATE_FLAG_ONLY;                                // [RULE9]
            st_nxt.lo0   = REG_RST;
            st_nxt.lo1   = REG_RST;
            st_nxt.pmask = REG_RST;
         end else begin
            st_nxt.key   = {VPN_W'(mask_off(PFN_W'(rd_e.virtual_page_pair_number), rd_e.mask)), // [RULE8] [RULE10]
                            5'h00, rd_e.address_space_tag};
            st_nxt.lo0   = {6'h00, mask_off(rd_e.pfn0, rd_e.mask),    // [RULE10]
                            rd_e.c0, rd_e.d0, rd_e.v0, rd_e.g};       // [RULE11]
            st_nxt.lo1   = {6'h00, mask_off(rd_e.pfn1, rd_e.mask),
                            rd_e.c1, rd_e.d1, rd_e.v1, rd_e.g};       // [RULE11]
            st_nxt.pmask = {3'h0, rd_e.mask, 13'h0000};               // [RULE8]
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_r <= STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tlb_key_hi_reg     = st_r.key;
   assign even_page_attr_reg = st_r.lo0;
   assign odd_page_attr_reg  = st_r.lo1;
   assign page_size_mask_reg = st_r.pmask;
   assign entry_pointer_reg  = st_r.ptr;
   assign op_done            = st_r.done;
   assign cop_unusable       = st_r.cpu;
   assign machine_check      = st_r.mchk;
   assign lookup_hit         = st_r.lk_hit;
   assign lookup_index       = st_r.lk_idx;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_probe_miss;
      go && op == OP_PROBE && !m_hit;
   endsequence
   sequence s_probe_hit;
      go && op == OP_PROBE && m_hit && !mc;
   endsequence
   sequence s_read_inv;
      go && op == OP_READ && isl_inv && rd_e.inv;
   endsequence
   sequence s_inval_write;
      go && op == OP_WRI && inval_wr;
   endsequence

   AST_DECODE: assert property (instr_valid && instr_word[24:6] != '0 |=> !op_done) // [RULE1]
      else $error("op done for word with nonzero middle bits");
   AST_PROBE_MISS: assert property (s_probe_miss |=> entry_pointer_reg[PTR_MISS_BIT]) // [RULE3]
      else $error("probe miss left top pointer bit clear");
   AST_PROBE_HIT: assert property (s_probe_hit |=> entry_pointer_reg == 32'($past(m_idx))) // [RULE2]
      else $error("probe hit loaded wrong index");
   AST_UNUSABLE: assert property (is_op && !cp0_usable                          // [RULE13]
                                  |=> cop_unusable && !op_done && !machine_check
                                  ##1 (cop_unusable == $past(is_op && !cp0_usable)))
      else $error("unusable fault not a single clean pulse");
   AST_READ_INV: assert property (s_read_inv |=> tlb_key_hi_reg == ENTRY_INVALIDATE_FLAG_ONLY  // [RULE9]
                                  && even_page_attr_reg == '0 && odd_page_attr_reg == '0
                                  && page_size_mask_reg == '0)
      else $error("read of invalid entry returned nonzero");
   AST_READ_G: assert property (go && op == OP_READ && !rd_e.inv && !mc          // [RULE11]
                                |=> even_page_attr_reg[0] == odd_page_attr_reg[0])
      else $error("global bit differs between attribute registers");
   AST_INVAL_MARK: assert property (s_inval_write                               // [RULE18]
                                    |=> !machine_check && tlb_q[$past(sel_idx)].inv)
      else $error("invalidating write did not mark entry");
   AST_WR_GLOBAL: assert property (go && op == OP_WRI && !inval_wr && !mc        // [RULE17]
                                   |=> tlb_q[$past(sel_idx)].g
                                       == ($past(st_r.lo0[0]) & $past(st_r.lo1[0]))
                                       && !tlb_q[$past(sel_idx)].inv)
      else $error("global bit or invalid marker wrong after write");
   AST_WRR_SLOT: assert property (go && op == OP_WRR && !mc                      // [RULE20]
                                  |=> !tlb_q[$past(replacement_ptr)].inv
                                      && tlb_q[$past(replacement_ptr)].address_space_tag
                                         == $past(st_r.key[ADDRESS_SPACE_TAG_W-1:0]))
      else $error("replacement write missed its slot");
   AST_REV_MC: assert property (arch_rev != REV_THREE && go                      // [RULE5]
                                && (op == OP_PROBE || op == OP_READ) |=> !machine_check)
      else $error("machine check on probe or read below third revision");
   AST_LOOKUP_INV: assert property (lookup_valid && !l_hit |=> !lookup_hit)      // [RULE19]
      else $error("lookup hit without a valid match");

endmodule

// ==== testbench/tlm_pipe_model.sv ====
// Purpose: pipeline stand-in issuing one coprocessor op per request
// Assumes: fire is held for one cycle per op
// Notes:   idle word keeps toggling so a stale decode cannot pass
module tlm_pipe_model import tlm_pkg::*; (
   input  wire logic       clk_sys,     // core clock
   input  wire logic       fire,        // issue request
   input  wire logic [5:0] fn,          // function code
   output logic            instr_valid, // word present
   output logic [31:0]     instr_word   // instruction
);
   timeunit 1ns;
   timeprecision 1ps;
   initial instr_word = 32'hA5A5A5A5;
   always @(posedge clk_sys) begin
      instr_valid <= fire;
      instr_word  <= fire ? {OPC_SYSCOP, 1'b1, 19'h00000, fn} : ~instr_word;
   end
endmodule

// ==== testbench/tlm_top_bench.sv ====
// Purpose: self-checking run of probe, read and both writes
// Assumes: default 16 entries, masked bits zeroed
// Notes:   each op leaves one note; the monitor pops it on the result pulse
module tlm_top_bench import tlm_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk_sys = 1'b0, rst_n = 1'b0, fire = 1'b0, cp0_usable = 1'b1;
   logic              sw_wr_en = 1'b0, lookup_valid = 1'b0;
   logic              instr_valid, op_done, cop_unusable, machine_check, lookup_hit;
   logic [5:0]        fn = 6'h00;
   logic [2:0]        isl = 3'h0, sw_wr_sel = 3'h0;
   logic [1:0]        rev = 2'h3;
   logic [3:0]        rep_ptr = 4'h0, lookup_index;
   logic [31:0]       instr_word, sw_wr_data = 32'h0, tlb_key_hi_reg, entry_pointer_reg;
   logic [31:0]       even_page_attr_reg, odd_page_attr_reg, page_size_mask_reg;
   logic [VPN_W-1:0]  lookup_virtual_page_pair_number = '0, va, vb;
   logic [ADDRESS_SPACE_TAG_W-1:0] lookup_address_space_tag = '0;
   logic [37:0]       nt, notes[$];
   int                err_count = 0, tests_run = 0;

   tlm_pipe_model pipe (.clk_sys, .fire, .fn, .instr_valid, .instr_word);
   tlm_top DUT (.clk_sys, .rst_n, .instr_valid, .instr_word, .cp0_usable,
      .arch_rev(rev), .invalidate_support_level(isl), .replacement_ptr(rep_ptr),
      .sw_wr_en, .sw_wr_sel, .sw_wr_data, .lookup_valid, .lookup_virtual_page_pair_number, .lookup_address_space_tag,
      .tlb_key_hi_reg, .even_page_attr_reg, .odd_page_attr_reg, .page_size_mask_reg,
      .entry_pointer_reg, .op_done, .cop_unusable, .machine_check, .lookup_hit,
      .lookup_index);

   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic swr(input logic [2:0] s, input logic [31:0] d);
      @(posedge clk_sys);
      sw_wr_en   <= 1'b1;
      sw_wr_sel  <= s;
      sw_wr_data <= d;
      @(posedge clk_sys);
      sw_wr_en   <= 1'b0;
   endtask

   // note: {done, unusable, mcheck, register select, expected value}
   task automatic op(input logic [5:0] f, input logic [37:0] note);
      int n;
      notes.push_back(note);
      @(posedge clk_sys);
      fire <= 1'b1;
      fn   <= f;
      @(posedge clk_sys);
      fire <= 1'b0;
      for (n = 0; n < 20 && notes.size() > 0; n++) @(posedge clk_sys);
      if (notes.size() > 0) begin
         check(32'h0, 32'h1);
         print_verdict();
      end
   endtask

   task automatic look(input logic [VPN_W-1:0] v, input logic [ADDRESS_SPACE_TAG_W-1:0] a,
                       input logic h, input logic [3:0] i);
      @(posedge clk_sys);
      lookup_valid <= 1'b1;
      lookup_virtual_page_pair_number  <= v;
      lookup_address_space_tag  <= a;
      @(posedge clk_sys);
      lookup_valid <= 1'b0;
      #1;
      check({31'h0, lookup_hit}, {31'h0, h});
      if (h) check({28'h0, lookup_index}, {28'h0, i});
   endtask

   function automatic logic [31:0] pick(input logic [2:0] s);
      case (s)
         SEL_KEY: return tlb_key_hi_reg;
         SEL_LO0: return even_page_attr_reg;
         SEL_LO1: return odd_page_attr_reg;
         SEL_MASK: return page_size_mask_reg;
         default: return entry_pointer_reg;
      endcase
   endfunction

   // pulses stand one cycle, so look mid-cycle
   always @(negedge clk_sys) begin
      if (op_done === 1'b1 || cop_unusable === 1'b1 || machine_check === 1'b1) begin
         if (notes.size() == 0) check(32'h0, 32'h1);
         else begin
            nt = notes.pop_front();
            check({29'h0, op_done, cop_unusable, machine_check}, {29'h0, nt[37:35]});
            check(pick(nt[34:32]), nt[31:0]);
         end
      end
   end

   initial begin
      va = VPN_W'($urandom(52));
      vb = VPN_W'($urandom);
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      swr(SEL_KEY, {va, 13'h0005});
      op(FN_PROBE, {3'b100, SEL_PTR, 32'h80000000});
      swr(SEL_LO0, 32'h00012347);
      swr(SEL_LO1, 32'h00045676);
      swr(SEL_PTR, 32'h00000003);
      op(FN_WR_IDX, {3'b100, SEL_PTR, 32'h00000003});
      look(va, 8'h05, 1'b1, 4'h3);
      look(va, 8'h06, 1'b0, 4'h0);
      op(FN_PROBE, {3'b100, SEL_PTR, 32'h00000003});
      op(FN_READ, {3'b100, SEL_LO0, 32'h00012346});
      check(odd_page_attr_reg, 32'h00045676);
      check(tlb_key_hi_reg, {va, 13'h0005});
      cp0_usable <= 1'b0;
      op(FN_WR_IDX, {3'b010, SEL_PTR, 32'h00000003});
      cp0_usable <= 1'b1;
      rep_ptr <= 4'($urandom_range(4, 15));
      swr(SEL_KEY, {vb, 13'h0009});
      op(FN_WR_REP, {3'b100, SEL_PTR, 32'h00000003});
      look(vb, 8'h09, 1'b1, rep_ptr);
      op(FN_WR_IDX, {3'b101, SEL_PTR, 32'h00000003});
      look(va, 8'h05, 1'b1, 4'h3);
      isl <= 3'h2;
      swr(SEL_KEY, {va, 13'h0405});
      op(FN_WR_IDX, {3'b100, SEL_PTR, 32'h00000003});
      look(va, 8'h05, 1'b0, 4'h0);
      op(FN_READ, {3'b100, SEL_KEY, ENTRY_INVALIDATE_FLAG_ONLY});
      check(even_page_attr_reg, 32'h0);
      swr(SEL_KEY, {va, 13'h0005});
      swr(SEL_MASK, 32'h00006000);
      op(FN_WR_IDX, {3'b100, SEL_PTR, 32'h00000003});
      look(va ^ 19'h00003, 8'h05, 1'b1, 4'h3);
      op(FN_READ, {3'b100, SEL_KEY, {va & 19'h7FFFC, 13'h0005}});
      // global entry over the same pages: a second hit the write check cannot see
      swr(SEL_LO0, 32'h00000001);
      swr(SEL_LO1, 32'h00000001);
      swr(SEL_KEY, {va, 13'h0009});
      op(FN_WR_REP, {3'b100, SEL_PTR, 32'h00000003});
      look(va, 8'h33, 1'b1, rep_ptr);
      swr(SEL_KEY, {va, 13'h0005});
      op(FN_PROBE, {3'b101, SEL_PTR, 32'h00000003});
      op(FN_READ, {3'b101, SEL_PTR, 32'h00000003});
      rev <= 2'h2;
      op(FN_PROBE, {3'b100, SEL_PTR, 32'h00000003});
      rev <= 2'h1;
      op(FN_READ, {3'b100, SEL_KEY, {va & 19'h7FFFC, 13'h0005}});
      print_verdict();
   end
endmodule
